// [inc/rbd_pkg.sv]
// package for the receive baseband demodulator: field widths, reset values, timing
// assumes a 100 MHz core clock and signed 16-bit i/q samples after decimation
`default_nettype none
package rbd_pkg;
    localparam int SAMPLE_W = 16;
    localparam int TAPS = 16;
    localparam int COEF_W = 12;
    localparam int STRENGTH_W = 8;
    localparam int BITRATE_W = 16;
    localparam int TRANS_WINDOW_BITS = 16;
    // modulation_select encodings
    localparam logic [1:0] MOD_FSK = 2'h0;
    localparam logic [1:0] MOD_OOK = 2'h1;
    // ook_threshold_kind encodings
    localparam logic [1:0] THR_FIXED = 2'h0;
    localparam logic [1:0] THR_PEAK = 2'h1;
    localparam logic [1:0] THR_AVG = 2'h2;
    // bandwidth mantissa codes and values
    localparam logic [1:0] MANT_CODE_16 = 2'h0;
    localparam logic [1:0] MANT_CODE_20 = 2'h1;
    localparam logic [1:0] MANT_CODE_24 = 2'h2;
    localparam logic [4:0] MANT_16 = 5'h10;
    localparam logic [4:0] MANT_20 = 5'h14;
    localparam logic [4:0] MANT_24 = 5'h18;
    localparam int FSK_EXP_OFFSET = 2;
    localparam int OOK_EXP_OFFSET = 3;
    localparam logic [2:0] DCC_RESET = 3'h2;
    // dcc cutoff at code 0 is 16 percent of bandwidth: shift of 3 ~ 1/8 band step
    localparam int DCC_BASE_SHIFT = 3;
    // 0.5 dB per lsb, so 6 dB is 12 lsb
    localparam logic [7:0] PEAK_DROP = 8'h0c;
    // signal strength acquisition spans two bit periods
    localparam int ACQ_BITS = 2;
    localparam int AVG_SHIFT = 4;
    localparam int CLK_MHZ = 100;
endpackage
`default_nettype wire

// [rtl/rbd_fir.sv]
// sixteen-tap fir channel filter, one output per input sample
// assumes coefficients are static while samples flow
`default_nettype none
module rbd_fir (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // stream
    input wire logic i_valid,
    input wire logic signed [rbd_pkg::SAMPLE_W-1:0] i_sample,
    input wire logic [2:0] i_bw_exponent,
    output logic o_valid,
    output logic signed [rbd_pkg::SAMPLE_W-1:0] o_sample
);
    logic signed [rbd_pkg::SAMPLE_W-1:0] taps [rbd_pkg::TAPS];
    logic signed [rbd_pkg::SAMPLE_W+5:0] acc;

    // symmetric hann-like window; the exponent shift only scales output gain, the band is fixed
    function automatic logic signed [rbd_pkg::COEF_W-1:0] coef(input int k);
        int m;
        m = (k < rbd_pkg::TAPS / 2) ? k + 1 : rbd_pkg::TAPS - k;
        return rbd_pkg::COEF_W'(m * 16);
    endfunction

    always_comb begin
        acc = '0;
        for (int k = 0; k < rbd_pkg::TAPS; k++) begin
            // widen first: a sample times a coefficient needs 28 bits
            acc = acc + (rbd_pkg::SAMPLE_W+6)'((32'(taps[k]) * 32'(coef(k))) >>> 11);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k < rbd_pkg::TAPS; k++) taps[k] <= '0;
        end else if (i_valid) begin
            taps[0] <= i_sample;
            for (int k = 1; k < rbd_pkg::TAPS; k++) taps[k] <= taps[k-1];
        end
    end

    // exponent codes 4 to 7 halve the output gain so narrow settings stay in range
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_valid <= 1'b0;
            o_sample <= '0;
        end else begin
            o_valid <= i_valid;
            if (i_valid) o_sample <= rbd_pkg::SAMPLE_W'(acc >>> (i_bw_exponent[2] ? 4 : 3));
        end
    end
endmodule
`default_nettype wire

// [rtl/rbd_bitsync.sv]
// bit synchronizer: nco at programmed rate, phase realigned on data edges
// assumes one raw data bit per clock, noisy near transitions
`default_nettype none
module rbd_bitsync (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_enable,
    input wire logic [rbd_pkg::BITRATE_W-1:0] i_bit_period,
    // data
    input wire logic i_raw,
    output logic o_data,
    output logic o_clk,
    output logic o_bit_tick
);
    logic [rbd_pkg::BITRATE_W-1:0] phase;
    logic raw_q;
    logic edge_seen;
    logic [rbd_pkg::BITRATE_W-1:0] half;

    assign edge_seen = raw_q != i_raw;
    assign half = i_bit_period >> 1;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) raw_q <= 1'b0;
        else raw_q <= i_raw;
    end

    // realign on edge, else free run at programmed period
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase <= '0;
        end else if (!i_enable || edge_seen) begin
            phase <= '0;
        end else if (phase + 1'b1 >= i_bit_period) begin
            phase <= '0;
        end else begin
            phase <= phase + 1'b1;
        end
    end

    // sample mid bit; clock rises at the sampling point
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data <= 1'b0;
            o_clk <= 1'b0;
            o_bit_tick <= 1'b0;
        end else begin
            o_bit_tick <= i_enable && !edge_seen && phase == half;
            if (i_enable && !edge_seen && phase == half) begin
                o_data <= raw_q;
                o_clk <= 1'b1;
            end else if (phase == '0) begin
                o_clk <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/rbd_demod.sv]
// receive baseband: channel filter, dc cancel, ook complex filter, cordic,
// signal strength, fsk/ook demod with three threshold modes, bit synchronizer
// assumes decimated i/q samples synchronous to i_clk; config static per packet
`default_nettype none
module rbd_demod (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // samples
    input wire logic i_iq_valid,
    input wire logic signed [rbd_pkg::SAMPLE_W-1:0] i_i,
    input wire logic signed [rbd_pkg::SAMPLE_W-1:0] i_q,
    // configuration
    input wire logic [1:0] i_modulation_select,
    input wire logic [1:0] i_bandwidth_mantissa,
    input wire logic [2:0] i_bandwidth_exponent,
    input wire logic [2:0] i_dc_cutoff_select,
    input wire logic [1:0] i_ook_threshold_kind,
    input wire logic [2:0] i_peak_decay_step,
    input wire logic [2:0] i_peak_decay_period,
    input wire logic [7:0] i_floor_threshold,
    input wire logic [7:0] i_signal_strength_threshold,
    input wire logic [7:0] i_bit_rate_high,
    input wire logic [7:0] i_bit_rate_low,
    input wire logic i_packet_mode,
    input wire logic i_sync_enable,
    // status
    output logic [7:0] o_signal_strength_value,
    output logic o_strength_above,
    output logic [4:0] o_bw_mantissa_value,
    output logic [3:0] o_bw_divider_log2,
    output logic [3:0] o_dc_cutoff_shift,
    output logic o_low_if_active,
    output logic o_lo_offset_half_bw,
    output logic [15:0] o_phase,
    // data out
    output logic o_data,
    output logic o_recovered_clock_pin,
    output logic o_bit_valid
);
    ////////////////////////////////////////////////////////////////////////////
    // bandwidth and dc configuration
    function automatic logic [4:0] mant_value(input logic [1:0] code);
        if (code == rbd_pkg::MANT_CODE_20) return rbd_pkg::MANT_20;
        else if (code == rbd_pkg::MANT_CODE_24) return rbd_pkg::MANT_24;
        else return rbd_pkg::MANT_16; // code 11 treated as 16
    endfunction

    logic is_ook;
    assign is_ook = i_modulation_select == rbd_pkg::MOD_OOK;

    // bw = reference_osc_frequency / (mant * 2^(exp+off)); the divider is exported for the filter clocks
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bw_mantissa_value <= rbd_pkg::MANT_16;
            o_bw_divider_log2 <= 4'h0;
            o_dc_cutoff_shift <= 4'h0;
            o_low_if_active <= 1'b0;
            o_lo_offset_half_bw <= 1'b0;
        end else begin
            o_bw_mantissa_value <= mant_value(i_bandwidth_mantissa);
            if (is_ook) o_bw_divider_log2 <= 4'(i_bandwidth_exponent) + 4'(rbd_pkg::OOK_EXP_OFFSET);
            else o_bw_divider_log2 <= 4'(i_bandwidth_exponent) + 4'(rbd_pkg::FSK_EXP_OFFSET);
            o_dc_cutoff_shift <= 4'(i_dc_cutoff_select) + 4'(rbd_pkg::DCC_BASE_SHIFT);
            o_low_if_active <= is_ook;
            o_lo_offset_half_bw <= is_ook;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // channel filter
    logic fi_valid;
    logic fq_valid;
    logic signed [rbd_pkg::SAMPLE_W-1:0] fi;
    logic signed [rbd_pkg::SAMPLE_W-1:0] fq;

    rbd_fir u_fir_i (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(i_iq_valid),
        .i_sample(i_i),
        .i_bw_exponent(i_bandwidth_exponent),
        .o_valid(fi_valid),
        .o_sample(fi)
    );
    rbd_fir u_fir_q (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(i_iq_valid),
        .i_sample(i_q),
        .i_bw_exponent(i_bandwidth_exponent),
        .o_valid(fq_valid),
        .o_sample(fq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // dc canceller: leaky mean removed, leak set by cutoff code
    logic signed [31:0] dc_i;
    logic signed [31:0] dc_q;
    logic signed [rbd_pkg::SAMPLE_W-1:0] ci;
    logic signed [rbd_pkg::SAMPLE_W-1:0] cq;
    assign ci = fi - rbd_pkg::SAMPLE_W'(dc_i >>> 16);
    assign cq = fq - rbd_pkg::SAMPLE_W'(dc_q >>> 16);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dc_i <= '0;
            dc_q <= '0;
        end else if (fi_valid) begin
            dc_i <= dc_i + ((32'(ci) <<< 16) >>> o_dc_cutoff_shift);
            dc_q <= dc_q + ((32'(cq) <<< 16) >>> o_dc_cutoff_shift);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // complex filter: in ook, mix by +if (quarter-rate rotation) to reject image
    logic [1:0] rot;
    logic signed [rbd_pkg::SAMPLE_W-1:0] xi;
    logic signed [rbd_pkg::SAMPLE_W-1:0] xq;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) rot <= 2'h0;
        else if (fi_valid) rot <= is_ook ? rot + 2'h1 : 2'h0;
    end
    always_comb begin
        xi = ci;
        xq = cq;
        if (is_ook) begin
            case (rot)
                2'h1: begin xi = -cq; xq = ci; end
                2'h2: begin xi = -ci; xq = -cq; end
                2'h3: begin xi = cq; xq = -ci; end
                default: begin xi = ci; xq = cq; end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cordic vectoring: phase and magnitude
    localparam int ITER = 12;
    logic signed [rbd_pkg::SAMPLE_W+1:0] cx;
    logic signed [rbd_pkg::SAMPLE_W+1:0] cy;
    logic signed [15:0] cz;
    logic [15:0] phase_q;
    logic [15:0] prev_phase;
    logic [rbd_pkg::SAMPLE_W+1:0] ampl;
    logic samp_valid;

    function automatic logic signed [15:0] atan_tab(input int k);
        logic signed [15:0] t [12];
        t = '{16'sh2000, 16'sh12e4, 16'sh09fb, 16'sh0511, 16'sh028b, 16'sh0146,
              16'sh00a3, 16'sh0051, 16'sh0029, 16'sh0014, 16'sh000a, 16'sh0005};
        return t[k];
    endfunction

    always_comb begin
        cx = (xi < 0) ? -(rbd_pkg::SAMPLE_W+2)'(xi) : (rbd_pkg::SAMPLE_W+2)'(xi);
        cy = (xi < 0) ? -(rbd_pkg::SAMPLE_W+2)'(xq) : (rbd_pkg::SAMPLE_W+2)'(xq);
        cz = (xi < 0) ? 16'sh8000 : 16'sh0000;
        for (int k = 0; k < ITER; k++) begin
            if (cy > 0) begin
                {cx, cy} = {cx + (cy >>> k), cy - (cx >>> k)};
                cz = cz + atan_tab(k);
            end else begin
                {cx, cy} = {cx - (cy >>> k), cy + (cx >>> k)};
                cz = cz - atan_tab(k);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_q <= '0;
            prev_phase <= '0;
            ampl <= '0;
            samp_valid <= 1'b0;
        end else begin
            samp_valid <= fi_valid;
            if (fi_valid) begin
                prev_phase <= phase_q;
                phase_q <= 16'(cz);
                ampl <= (rbd_pkg::SAMPLE_W+2)'(cx);
            end
        end
    end
    assign o_phase = phase_q;

    ////////////////////////////////////////////////////////////////////////////
    // signal strength: log2 of amplitude in half-dB steps
    function automatic logic [7:0] to_half_db(input logic [rbd_pkg::SAMPLE_W+1:0] a);
        logic [7:0] r;
        r = 8'h00;
        for (int k = 0; k < rbd_pkg::SAMPLE_W + 2; k++) begin
            if (a[k]) r = 8'(k * 12) + (k > 0 ? 8'(a[k-1] ? 6 : 0) : 8'h00);
        end
        return r;
    endfunction

    logic [rbd_pkg::BITRATE_W-1:0] bit_period;
    logic [rbd_pkg::BITRATE_W:0] acq_cnt;
    logic [7:0] strength;
    logic [15:0] acc_peak;
    assign bit_period = {i_bit_rate_high, i_bit_rate_low};
    assign strength = to_half_db(ampl);

    // acquisition window of two bit periods; result latched at its end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acq_cnt <= '0;
            acc_peak <= '0;
            o_signal_strength_value <= 8'h00;
            o_strength_above <= 1'b0;
        end else if (acq_cnt + 1'b1 >= (rbd_pkg::BITRATE_W+1)'(bit_period) * rbd_pkg::ACQ_BITS) begin
            acq_cnt <= '0;
            acc_peak <= '0;
            o_strength_above <= 8'(acc_peak) > i_signal_strength_threshold;
            if (8'(acc_peak) > i_signal_strength_threshold)
                o_signal_strength_value <= 8'(acc_peak);
            else
                o_signal_strength_value <= 8'h00;
        end else begin
            acq_cnt <= acq_cnt + 1'b1;
            if (samp_valid && 16'(strength) > acc_peak) acc_peak <= 16'(strength);
            // a raised threshold hides the held value at once
            if (o_signal_strength_value <= i_signal_strength_threshold)
                o_signal_strength_value <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ook threshold generation
    logic [7:0] peak;
    logic [7:0] avg;
    logic [9:0] avg_acc;
    logic [7:0] decay_cnt;
    logic [7:0] threshold;
    logic ook_bit;
    logic fsk_bit;
    logic [15:0] dphase;

    always_comb begin
        if (i_ook_threshold_kind == rbd_pkg::THR_PEAK)
            threshold = (peak > rbd_pkg::PEAK_DROP) ? peak - rbd_pkg::PEAK_DROP : 8'h00;
        else if (i_ook_threshold_kind == rbd_pkg::THR_AVG)
            threshold = avg;
        else
            threshold = i_floor_threshold;
    end
    assign ook_bit = strength > threshold;

    // peak: instant rise, stepped decay down to floor on zero or silence
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            peak <= 8'h00;
            decay_cnt <= 8'h00;
        end else if (samp_valid) begin
            if (strength > peak) begin
                peak <= strength;
                decay_cnt <= 8'h00;
            end else if (!ook_bit) begin
                if (decay_cnt >= (8'h01 << i_peak_decay_period)) begin
                    decay_cnt <= 8'h00;
                    if (peak > i_floor_threshold + 8'(i_peak_decay_step) + 8'h01)
                        peak <= peak - 8'(i_peak_decay_step) - 8'h01;
                    else
                        peak <= i_floor_threshold;
                end else begin
                    decay_cnt <= decay_cnt + 8'h01;
                end
            end
        end
    end

    // running average suits dc-free codes only; biased by long runs otherwise
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            avg_acc <= '0;
        end else if (samp_valid) begin
            avg_acc <= avg_acc - 10'(avg_acc >> rbd_pkg::AVG_SHIFT) + 10'(strength >> 2);
        end
    end
    assign avg = 8'(avg_acc >> 2);

    // fsk: sign of phase derivative
    assign dphase = phase_q - prev_phase;
    assign fsk_bit = !dphase[15];

    ////////////////////////////////////////////////////////////////////////////
    // bit synchronizer and output selection
    logic raw_bit;
    logic sync_on;
    logic sync_data;
    logic sync_clk;
    logic sync_tick;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) raw_bit <= 1'b0;
        else if (samp_valid) raw_bit <= is_ook ? ook_bit : fsk_bit;
    end
    assign sync_on = i_packet_mode || i_sync_enable;

    rbd_bitsync u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_enable(sync_on),
        .i_bit_period(bit_period),
        .i_raw(raw_bit),
        .o_data(sync_data),
        .o_clk(sync_clk),
        .o_bit_tick(sync_tick)
    );

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data <= 1'b0;
            o_recovered_clock_pin <= 1'b0;
            o_bit_valid <= 1'b0;
        end else begin
            o_data <= sync_on ? sync_data : raw_bit;
            o_recovered_clock_pin <= sync_on && sync_clk;
            o_bit_valid <= sync_on && sync_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    chk_bw_exp_ook: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_ook |=> (o_bw_divider_log2 == 4'($past(i_bandwidth_exponent)) + 4'h3)
                   || $changed(i_modulation_select))
        else $error("ook bandwidth divider wrong");
    chk_bw_exp_fsk: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_modulation_select == rbd_pkg::MOD_FSK && $stable(i_bandwidth_exponent))
        |=> o_bw_divider_log2 == 4'($past(i_bandwidth_exponent)) + 4'h2)
        else $error("fsk bandwidth divider wrong");
    chk_mant_map: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_bandwidth_mantissa == 2'h2 |=> o_bw_mantissa_value == 5'h18)
        else $error("mantissa 10 must give 24");
    chk_low_if: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        is_ook |=> o_low_if_active && o_lo_offset_half_bw)
        else $error("low-if not engaged in ook");
    chk_strength_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_signal_strength_value != 8'h00 |-> o_signal_strength_value > i_signal_strength_threshold
        || $changed(i_signal_strength_threshold))
        else $error("strength shown below threshold");
    chk_peak_rise: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (samp_valid && strength > peak) |=> peak == $past(strength))
        else $error("peak did not follow rising strength");
    chk_peak_floor: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (samp_valid && $stable(i_floor_threshold) && peak >= i_floor_threshold)
        |=> peak >= i_floor_threshold)
        else $error("peak fell below floor");
    chk_thr_peak: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ook_threshold_kind == rbd_pkg::THR_PEAK && peak > 8'h0c) |-> threshold == peak - 8'h0c)
        else $error("peak threshold not six dB down");
    chk_sync_pkt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !sync_on |=> !o_recovered_clock_pin && !o_bit_valid)
        else $error("sync output while disabled");
endmodule
`default_nettype wire

// [test/rbd_tx_model.sv]
// ook transmitter model: alternating bits, one i/q sample per clock
// assumes the bench sets a bit period equal to the receiver's
`default_nettype none
module rbd_tx_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_on,
    input wire logic [15:0] i_period,
    // samples
    output logic o_valid,
    output logic signed [15:0] o_i,
    output logic signed [15:0] o_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt;
    logic bit_val;
    logic [4:0] ph;
    logic signed [15:0] amp;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) ph <= 5'h00;
        else ph <= ph + 5'h01;
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 16'h0000;
            bit_val <= 1'b0;
        end else if (cnt + 16'h0001 >= i_period) begin // same rate as receiver
            cnt <= 16'h0000;
            bit_val <= ~bit_val; // a transition every bit
        end else begin
            cnt <= cnt + 16'h0001;
        end
    end
    // when off the lines keep changing so no stale level passes for data
    // slow quadrature tone: a bare dc carrier would be eaten by the dc canceller
    assign amp = bit_val ? 16'sh4000 : 16'sh0010;
    assign o_valid = i_on;
    assign o_i = !i_on ? {cnt[0], 15'h0} : (ph[4] ? -amp : amp);
    assign o_q = !i_on ? ~o_i : ((ph[4] ^ ph[3]) ? -amp : amp);
endmodule
`default_nettype wire

// [test/rbd_demod_test.sv]
// self-checking bench for the receive baseband demodulator
// assumes the ook transmitter model feeds the sample port
`default_nettype none
module rbd_demod_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic on = 1'b0;
    logic iq_valid;
    logic signed [15:0] si, sq;
    logic [1:0] mod = 2'h1, mant = 2'h0, kind = 2'h0;
    logic [2:0] bexp = 3'h0, dcc = 3'h2;
    logic [7:0] str_thr = 8'h00;
    logic pkt = 1'b1, sync_en = 1'b0;
    // 40-clock bits sit well below twice the channel bandwidth
    // only ook is sent, so no modulation index applies
    logic [15:0] period = 16'h0028;
    logic [7:0] strength;
    logic [4:0] mant_val;
    logic [3:0] div_log2, dcc_shift;
    logic above, data, pin, bit_valid, low_if, lo_off;
    int fail_count = 0, compares = 0, pulses, flips, highs;
    always #5 clk = ~clk;
    rbd_tx_model tx (.i_clk(clk), .i_rst_n(rst_n), .i_on(on), .i_period(period),
        .o_valid(iq_valid), .o_i(si), .o_q(sq));
    rbd_demod dut (.i_clk(clk), .i_rst_n(rst_n), .i_iq_valid(iq_valid), .i_i(si), .i_q(sq),
        .i_modulation_select(mod), .i_bandwidth_mantissa(mant), .i_bandwidth_exponent(bexp),
        .i_dc_cutoff_select(dcc), .i_ook_threshold_kind(kind), .i_peak_decay_step(3'h0),
        .i_peak_decay_period(3'h1), .i_floor_threshold(8'h60),
        .i_signal_strength_threshold(str_thr), .i_bit_rate_high(period[15:8]),
        .i_bit_rate_low(period[7:0]), .i_packet_mode(pkt), .i_sync_enable(sync_en),
        .o_signal_strength_value(strength), .o_strength_above(above),
        .o_bw_mantissa_value(mant_val), .o_bw_divider_log2(div_log2),
        .o_dc_cutoff_shift(dcc_shift), .o_low_if_active(low_if), .o_lo_offset_half_bw(lo_off),
        .o_phase(), .o_data(data), .o_recovered_clock_pin(pin), .o_bit_valid(bit_valid));
    ////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // counts bit strobes, data edges and clock-pin highs over n cycles
    task automatic watch(input int n);
        logic last;
        pulses = 0;
        flips = 0;
        highs = 0;
        last = data;
        repeat (n) begin
            settle(1);
            pulses += (bit_valid === 1'b1);
            flips += (data !== last);
            highs += (pin === 1'b1);
            last = data;
        end
    endtask
    initial begin
        int m, e, k;
        settle(12);
        check("reset mantissa", 16'(mant_val), 16'h0010);
        @(posedge clk) rst_n <= 1'b1;
        for (k = 0; k < 2; k++) for (m = 0; m < 3; m++) for (e = 0; e < 8; e++) begin
            @(posedge clk);
            mod <= 2'(k);
            mant <= 2'(m);
            bexp <= 3'(e);
            dcc <= 3'(e);
            settle(2);
            check("mantissa", 16'(mant_val), 16'(16 + 4 * m));
            check("divider", 16'(div_log2), 16'(e + 2 + k));
            check("dc shift", 16'(dcc_shift), 16'(e + 3));
            check("low if", 16'({low_if, lo_off}), 16'(k * 3));
        end
        @(posedge clk);
        mod <= 2'h1;
        on <= 1'b1;
        // every threshold kind must follow the alternating preamble
        for (k = 0; k < 3; k++) begin
            @(posedge clk) kind <= 2'(k);
            settle(480); // twelve preamble bits before lock
            watch(640);
            check("bit pulses", 16'(pulses), 16'h0010);
            check("data flips", 16'(flips >= 15), 16'h0001);
        end
        check("strength above", 16'(above), 16'h0001);
        @(posedge clk) str_thr <= 8'hff;
        settle(240);
        check("strength hidden", 16'(strength), 16'h0000);
        check("strength flag", 16'(above), 16'h0000);
        @(posedge clk);
        pkt <= 1'b0;
        sync_en <= 1'b0;
        settle(10);
        watch(200);
        check("pin off", 16'(highs), 16'h0000);
        @(posedge clk) sync_en <= 1'b1;
        settle(480);
        watch(200);
        check("pin on", 16'(highs > 0), 16'h0001);
        check("cont pulses", 16'(pulses), 16'h0005);
        conclude();
    end
    // a hung run still reaches the verdict
    initial begin
        settle(20000);
        check("run time", 16'h0000, 16'h0001);
        conclude();
    end
endmodule
`default_nettype wire
